// File: design/focc_pkg.sv
// Purpose: Shared constants and types of the format override and word clock configuration block.
// Assumes: One 100 MHz clock; all pins synchronous to it.
// Notes: Registers are eight bits wide and sit behind the ten-bit shared port.
package focc_pkg;
  localparam int REG_W = 8;
  localparam int PORT_W = 10;
  localparam int HALF_W = 10;
  localparam int VID_W = 20;
  localparam int IO_W = 8;
  localparam int LINE_W = 11;

  localparam logic [REG_W-1:0] ADDR_FORMAT = 8'h0b;
  localparam logic [REG_W-1:0] ADDR_VIDCTL = 8'h55;

  localparam int FMT_HD_RESTRICT_BIT = 5;
  localparam int FMT_SUB_MSB = 4;
  localparam int FMT_SD_HD_BIT = 4;
  localparam int VIDCTL_EXT_CLK_BIT = 0;
  localparam logic [FMT_SUB_MSB:0] SUB_GENERIC_HD = 5'h1f;

  localparam logic [1:0] CTRL_TAG = 2'h3;
  localparam int TAG_LSB = 8;

  localparam logic [REG_W-1:0] FORMAT_RST = 8'h00;
  localparam logic [REG_W-1:0] VIDCTL_RST = 8'h00;

  localparam int IO_FMT_BIT = 3;
  localparam int IO_LOCK_BIT = 4;

  localparam int WCLK_HALF_DEF = 2;
  localparam logic BIAS_IDLE_LEVEL = 1'b1;

  typedef enum {FOCC_PH_ADDR, FOCC_PH_DATA} focc_phase_t;
endpackage : focc_pkg

// File: design/focc_stream_if.sv
// Purpose: Valid and ready stream carrier between the block and its word buffer.
// Assumes: Both ends run on the same clock.
// Notes: A word moves in each cycle where valid and ready are both high.
`timescale 1ns/1ps
`default_nettype none
interface focc_stream_if #(parameter int W = 20);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : focc_stream_if
`default_nettype wire

// File: design/focc_buf.sv
// Purpose: Two-entry word buffer that absorbs a stall of the receiver.
// Assumes: Synchronous active-high reset.
// Notes: Ready on the input is low only when both entries hold words.
`timescale 1ns/1ps
`default_nettype none
module focc_buf #(
  parameter int W = 20,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Streams
  focc_stream_if.snk s_in,
  focc_stream_if.src s_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, next_wr_ptr;
  logic [PW-1:0] rd_ptr, next_rd_ptr;
  logic [CW-1:0] count, next_count;
  logic push, pop;

  assign s_in.ready = (count != CW'(DEPTH));
  assign s_out.valid = (count != '0);
  assign s_out.data = mem[rd_ptr];
  assign push = s_in.valid && s_in.ready;
  assign pop = s_out.valid && s_out.ready;

  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push)
    begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage is not reset; only words counted as present are ever read.
  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= s_in.data;
    end
  end

  buf_bound_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    count <= CW'(DEPTH)) else $error("word buffer holds more than its depth");
endmodule : focc_buf
`default_nettype wire

// File: design/focc_top.sv
// Purpose: Format override and external word clock configuration of a video deserializer.
// Assumes: Port strobe and word clock pins are synchronous to i_mclk.
// Notes: A control write is an address word then a data word, both tagged in the top bits.
`timescale 1ns/1ps
`default_nettype none
module focc_top #(
  parameter int WCLK_HALF = focc_pkg::WCLK_HALF_DEF
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Shared ancillary and control port
  input wire logic i_port_strobe,
  input wire logic i_port_function_select,
  input wire logic i_port_rd_wr,
  input wire logic [focc_pkg::PORT_W-1:0] i_ancillary_port,
  output logic [focc_pkg::PORT_W-1:0] o_ancillary_port,
  output logic o_ancillary_port_oe_n,
  // Recovered stream from the deserializer core
  input wire logic i_vid_valid,
  input wire logic [focc_pkg::HALF_W-1:0] i_vid_luma,
  input wire logic [focc_pkg::HALF_W-1:0] i_vid_chroma,
  output logic o_vid_in_ready,
  input wire logic i_anc_valid,
  input wire logic [focc_pkg::PORT_W-1:0] i_anc_word,
  input wire logic [focc_pkg::LINE_W-1:0] i_line_num,
  input wire logic i_crc_err,
  input wire logic i_det_sd_hd,
  input wire logic i_lock_detect,
  input wire logic i_rate_tick,
  // Parallel video output
  input wire logic i_vid_ready,
  output logic [focc_pkg::VID_W-1:0] o_vid_data,
  output logic o_vid_data_valid,
  // Word clock pin
  input wire logic i_video_word_clock,
  output logic o_video_word_clock,
  output logic o_video_word_clock_oe_n,
  // Bias pin
  output logic o_bias_pin,
  output logic o_bias_pin_oe_n,
  // Core controls and status
  output logic o_auto_detect_en,
  output logic o_trs_detect_en,
  output logic [focc_pkg::LINE_W-1:0] o_line_num,
  output logic o_crc_err,
  output logic [focc_pkg::IO_W-1:0] o_io_port
);
  import focc_pkg::*;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  localparam int DW = (WCLK_HALF > 1) ? $clog2(WCLK_HALF) : 1;

  // Port decode.
  logic strobe_q, port_edge, ctrl_write, ctrl_read, anc_read, tag_ok;
  logic [REG_W-1:0] format_cfg, next_format_cfg;
  logic [REG_W-1:0] vid_ctl, next_vid_ctl;
  logic [REG_W-1:0] addr_ptr, next_addr_ptr;
  focc_phase_t phase, next_phase;
  logic [PORT_W-1:0] port_out, next_port_out;
  logic [REG_W-1:0] rd_value;
  logic hd_restrict_mode, generic_mode, ext_word_clock_select;

  assign port_edge = i_port_strobe && !strobe_q;
  assign ctrl_write = port_edge && i_port_function_select && !i_port_rd_wr;
  assign ctrl_read = port_edge && i_port_function_select && i_port_rd_wr;
  assign anc_read = port_edge && !i_port_function_select && i_port_rd_wr;
  assign tag_ok = (i_ancillary_port[PORT_W-1:TAG_LSB] == CTRL_TAG);

  assign hd_restrict_mode = format_cfg[FMT_HD_RESTRICT_BIT];
  assign generic_mode = hd_restrict_mode && (format_cfg[FMT_SUB_MSB:0] == SUB_GENERIC_HD);
  assign ext_word_clock_select = vid_ctl[VIDCTL_EXT_CLK_BIT];

  always_comb
  begin
    unique case (addr_ptr)
      ADDR_FORMAT: rd_value = format_cfg;
      ADDR_VIDCTL: rd_value = vid_ctl;
      default: rd_value = '0;
    endcase
  end

  // Ancillary extraction state.
  logic [PORT_W-1:0] anc_hold, next_anc_hold;
  logic anc_avail, next_anc_avail, anc_take;

  assign anc_take = i_anc_valid && !generic_mode;

  always_comb
  begin
    next_format_cfg = format_cfg;
    next_vid_ctl = vid_ctl;
    next_addr_ptr = addr_ptr;
    next_phase = phase;
    next_port_out = port_out;
    next_anc_hold = anc_take ? i_anc_word : anc_hold;
    // A fresh word wins over the read that clears the flag.
    next_anc_avail = anc_take || (anc_avail && !anc_read);
    if (ctrl_write && tag_ok)
    begin
      unique case (phase)
        FOCC_PH_ADDR:
        begin
          next_addr_ptr = i_ancillary_port[REG_W-1:0];
          next_phase = FOCC_PH_DATA;
        end
        FOCC_PH_DATA:
        begin
          if (addr_ptr == ADDR_FORMAT)
          begin
            next_format_cfg = i_ancillary_port[REG_W-1:0];
          end
          if (addr_ptr == ADDR_VIDCTL)
          begin
            next_vid_ctl = i_ancillary_port[REG_W-1:0];
          end
          next_phase = FOCC_PH_ADDR;
        end
      endcase
    end
    if (ctrl_read)
    begin
      next_port_out = {CTRL_TAG, rd_value};
      next_phase = FOCC_PH_ADDR;
    end
    else if (anc_read)
    begin
      next_port_out = anc_avail ? anc_hold : '0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      strobe_q <= 1'b0;
      format_cfg <= FORMAT_RST;
      vid_ctl <= VIDCTL_RST;
      addr_ptr <= '0;
      phase <= FOCC_PH_ADDR;
      port_out <= '0;
      anc_hold <= '0;
      anc_avail <= 1'b0;
    end
    else
    begin
      strobe_q <= i_port_strobe;
      format_cfg <= next_format_cfg;
      vid_ctl <= next_vid_ctl;
      addr_ptr <= next_addr_ptr;
      phase <= next_phase;
      port_out <= next_port_out;
      anc_hold <= next_anc_hold;
      anc_avail <= next_anc_avail;
    end
  end

  assign o_ancillary_port = port_out;
  assign o_ancillary_port_oe_n = !i_port_rd_wr;

  // Word clock generation and selection.
  logic [DW-1:0] div_cnt, next_div_cnt;
  logic int_wclk, next_int_wclk, ext_wclk_q, wclk_prev, wclk_level, wclk_fall, ext_rise;

  always_comb
  begin
    next_div_cnt = div_cnt + 1'b1;
    next_int_wclk = int_wclk;
    if (div_cnt == DW'(WCLK_HALF - 1))
    begin
      next_div_cnt = '0;
      next_int_wclk = !int_wclk;
    end
  end

  assign wclk_level = ext_word_clock_select ? ext_wclk_q : int_wclk;
  assign wclk_fall = wclk_prev && !wclk_level;
  assign ext_rise = ext_word_clock_select && wclk_level && !wclk_prev;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      div_cnt <= '0;
      int_wclk <= 1'b0;
      ext_wclk_q <= 1'b0;
      wclk_prev <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      int_wclk <= next_int_wclk;
      ext_wclk_q <= i_video_word_clock;
      wclk_prev <= wclk_level;
    end
  end

  assign o_video_word_clock = int_wclk;
  assign o_video_word_clock_oe_n = ext_word_clock_select;

  // Video path through the two-entry buffer.
  focc_stream_if #(.W(VID_W)) vin ();
  focc_stream_if #(.W(VID_W)) vout ();
  logic [VID_W-1:0] vid_q, next_vid_q;
  logic vid_valid_q, next_vid_valid_q;

  assign vin.valid = i_vid_valid;
  assign vin.data = {i_vid_luma, i_vid_chroma};
  assign o_vid_in_ready = vin.ready;
  assign vout.ready = wclk_fall && i_vid_ready;

  focc_buf #(.W(VID_W), .DEPTH(2)) u_buf (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .s_in(vin),
    .s_out(vout)
  );

  always_comb
  begin
    next_vid_q = vid_q;
    next_vid_valid_q = vid_valid_q;
    if (vout.ready)
    begin
      next_vid_q = vout.valid ? vout.data : vid_q;
      next_vid_valid_q = vout.valid;
    end
  end

  // Core gating, detector and IO port.
  logic pfd_up, next_pfd_up, pfd_dn, next_pfd_dn;
  logic bias_q, next_bias_q, bias_oe_n_q, next_bias_oe_n_q;
  logic [LINE_W-1:0] line_q, next_line_q;
  logic crc_q, next_crc_q;
  logic [IO_W-1:0] io_q, next_io_q;
  logic sd_hd_flag;

  assign sd_hd_flag = hd_restrict_mode ? format_cfg[FMT_SD_HD_BIT] : i_det_sd_hd;

  always_comb
  begin
    next_pfd_up = ext_word_clock_select && (pfd_up || i_rate_tick);
    next_pfd_dn = ext_word_clock_select && (pfd_dn || ext_rise);
    if (next_pfd_up && next_pfd_dn)
    begin
      next_pfd_up = 1'b0;
      next_pfd_dn = 1'b0;
    end
    next_bias_q = ext_word_clock_select ? pfd_up : BIAS_IDLE_LEVEL;
    next_bias_oe_n_q = ext_word_clock_select && !(pfd_up ^ pfd_dn);
    next_line_q = generic_mode ? '0 : i_line_num;
    next_crc_q = !generic_mode && i_crc_err;
    next_io_q = '0;
    next_io_q[IO_FMT_BIT] = sd_hd_flag;
    next_io_q[IO_LOCK_BIT] = i_lock_detect;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      vid_q <= '0;
      vid_valid_q <= 1'b0;
      pfd_up <= 1'b0;
      pfd_dn <= 1'b0;
      bias_q <= BIAS_IDLE_LEVEL;
      bias_oe_n_q <= 1'b0;
      line_q <= '0;
      crc_q <= 1'b0;
      io_q <= '0;
    end
    else
    begin
      vid_q <= next_vid_q;
      vid_valid_q <= next_vid_valid_q;
      pfd_up <= next_pfd_up;
      pfd_dn <= next_pfd_dn;
      bias_q <= next_bias_q;
      bias_oe_n_q <= next_bias_oe_n_q;
      line_q <= next_line_q;
      crc_q <= next_crc_q;
      io_q <= next_io_q;
    end
  end

  assign o_vid_data = vid_q;
  assign o_vid_data_valid = vid_valid_q;
  assign o_bias_pin = bias_q;
  assign o_bias_pin_oe_n = bias_oe_n_q;
  assign o_auto_detect_en = !hd_restrict_mode;
  assign o_trs_detect_en = !generic_mode;
  assign o_line_num = line_q;
  assign o_crc_err = crc_q;
  assign o_io_port = io_q;

  sequence data_wr_s(logic [REG_W-1:0] a);
    ctrl_write && tag_ok && phase == FOCC_PH_DATA && addr_ptr == a;
  endsequence

  fmt_write_a: assert property (data_wr_s(ADDR_FORMAT) |=>
    format_cfg == $past(i_ancillary_port[REG_W-1:0])) else $error("format write lost");
  tag_reject_a: assert property (ctrl_write && !tag_ok |=>
    $stable(format_cfg) && $stable(vid_ctl) && $stable(addr_ptr)) else $error("untagged word used");
  generic_word_a: assert property (ctrl_write && tag_ok && phase == FOCC_PH_DATA
    && addr_ptr == ADDR_FORMAT && i_ancillary_port == 10'h33f
    |=> generic_mode && !o_auto_detect_en) else $error("generic word not accepted");
  trs_off_a: assert property (generic_mode |-> !o_trs_detect_en ##1
    (!o_crc_err && o_line_num == '0)) else $error("timing features live in generic mode");
  anc_block_a: assert property (generic_mode && i_anc_valid |=>
    $stable(anc_hold)) else $error("extraction in generic mode");
  video_align_a: assert property (vout.ready && vout.valid |=>
    o_vid_data == $past(vout.data) && o_vid_data_valid) else $error("video word misplaced");
  ext_dir_a: assert property (data_wr_s(ADDR_VIDCTL) ##1 ext_word_clock_select
    |-> o_video_word_clock_oe_n) else $error("word clock pin still driven");
  pfd_up_a: assert property (ext_word_clock_select && i_rate_tick && !pfd_up && !pfd_dn
    && !ext_rise ##1 ext_word_clock_select |=> o_bias_pin && !o_bias_pin_oe_n)
    else $error("detector gives no up output");
  bias_idle_a: assert property (!ext_word_clock_select |=>
    o_bias_pin && !o_bias_pin_oe_n) else $error("bias pin not in bias role");
  io_map_a: assert property (1'b1 |=> o_io_port[IO_LOCK_BIT] == $past(i_lock_detect)
    && o_io_port[IO_FMT_BIT] == $past(sd_hd_flag)) else $error("IO port mapping wrong");
  fall_only_a: assert property ($changed(o_vid_data) |-> $past(wclk_fall))
    else $error("video changed off falling edge");
  cfg_hold_a: assert property (!(ctrl_write && tag_ok && phase == FOCC_PH_DATA) |=>
    $stable(format_cfg) && $stable(vid_ctl)) else $error("configuration drifted");
endmodule : focc_top
`default_nettype wire

// File: verif/focc_sink_model.sv
// Purpose: Downstream video receiver that stands on the far side of the parallel output.
// Assumes: Word clock level is seen in the i_mclk domain.
// Notes: Mode 0 accepts every word, 1 every other word, 2 stalls.
`timescale 1ns/1ps
`default_nettype none
module focc_sink_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Behaviour select
  input wire logic [1:0] i_mode,
  // Video side
  input wire logic i_wclk,
  input wire logic i_valid,
  input wire logic [19:0] i_data,
  output logic o_ready,
  // Captured words
  output logic o_cap_v,
  output logic [19:0] o_cap_d
);
  logic prev;
  logic took;

  always @(posedge i_mclk)
  begin
    o_cap_v <= 1'b0;
    if (i_rst)
    begin
      prev <= 1'b0;
      took <= 1'b0;
      o_ready <= 1'b0;
    end
    else
    begin
      prev <= i_wclk;
      // Ready only moves at a rising word edge, so it is steady over every falling edge.
      if (prev && !i_wclk)
        took <= o_ready;
      if (!prev && i_wclk)
      begin
        if (took && i_valid)
        begin
          o_cap_v <= 1'b1;
          o_cap_d <= i_data;
        end
        took <= 1'b0;
        o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && !o_ready);
      end
    end
  end
endmodule : focc_sink_model
`default_nettype wire

// File: verif/focc_top_tb_top.sv
// Purpose: Self-checking bench of the format override and word clock block.
// Assumes: Word clock half period of two cycles.
// Notes: Expected words and reads wait in queues until the outputs show them.
`timescale 1ns/1ps
`default_nettype none
module focc_top_tb_top;
  import focc_pkg::*;
  logic i_mclk, i_rst, strobe, fsel, rdwr, vid_valid, anc_valid, crc_err, det_sd_hd, lock;
  logic tick, vcxo, port_oe_n, in_ready, vid_rdy, dvalid, wclk_o, wclk_oe_n, bias, bias_oe_n;
  logic auto_en, trs_en, crc_o, cap_v, rd_pend;
  logic [PORT_W-1:0] host_d, anc_word, port_out, rd_mask;
  logic [HALF_W-1:0] luma, chroma;
  logic [LINE_W-1:0] line_num, line_out;
  logic [VID_W-1:0] vid_data, cap_d;
  logic [IO_W-1:0] io;
  logic [1:0] mode;
  logic [15:0] lfsr_s;
  logic [PORT_W-1:0] rq[$];
  logic [VID_W-1:0] vq[$];
  int errors, total_checks;
  wire logic [PORT_W-1:0] port_wire = port_oe_n ? host_d : port_out;
  wire logic wclk_wire = wclk_oe_n ? vcxo : wclk_o;

  focc_top #(.WCLK_HALF(2)) u_focc_top (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_port_strobe(strobe), .i_port_function_select(fsel), .i_port_rd_wr(rdwr),
    .i_ancillary_port(port_wire), .o_ancillary_port(port_out),
    .o_ancillary_port_oe_n(port_oe_n), .i_vid_valid(vid_valid), .i_vid_luma(luma),
    .i_vid_chroma(chroma), .o_vid_in_ready(in_ready), .i_anc_valid(anc_valid),
    .i_anc_word(anc_word), .i_line_num(line_num), .i_crc_err(crc_err),
    .i_det_sd_hd(det_sd_hd), .i_lock_detect(lock), .i_rate_tick(tick),
    .i_vid_ready(vid_rdy), .o_vid_data(vid_data), .o_vid_data_valid(dvalid),
    .i_video_word_clock(wclk_wire), .o_video_word_clock(wclk_o),
    .o_video_word_clock_oe_n(wclk_oe_n), .o_bias_pin(bias), .o_bias_pin_oe_n(bias_oe_n),
    .o_auto_detect_en(auto_en), .o_trs_detect_en(trs_en), .o_line_num(line_out),
    .o_crc_err(crc_o), .o_io_port(io));

  focc_sink_model u_focc_sink_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_mode(mode),
    .i_wclk(wclk_wire), .i_valid(dvalid), .i_data(vid_data), .o_ready(vid_rdy),
    .o_cap_v(cap_v), .o_cap_d(cap_d));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [VID_W-1:0] seen, input logic [VID_W-1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask : settle

  // The strobe drops after one cycle, so a low cycle always separates two transfers.
  task automatic port_op(input logic f, input logic rw, input logic [PORT_W-1:0] d);
    @(posedge i_mclk);
    strobe <= 1'b1;
    fsel <= f;
    rdwr <= rw;
    host_d <= d;
    @(posedge i_mclk);
    strobe <= 1'b0;
    @(posedge i_mclk);
  endtask : port_op

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    port_op(1'b1, 1'b0, {CTRL_TAG, a});
    port_op(1'b1, 1'b0, {CTRL_TAG, v});
  endtask : wr

  task automatic rd(input logic f, input logic [7:0] a, input logic [PORT_W-1:0] e);
    if (f)
      port_op(1'b1, 1'b0, {CTRL_TAG, a});
    port_op(f, 1'b1, 10'h000);
    @(posedge i_mclk);
    rd_mask = f ? 10'h0ff : 10'h3ff;
    rq.push_back(e);
    rd_pend = 1'b1;
    check(20'(port_oe_n), 20'h0);
  endtask : rd

  task automatic pulse_anc(input logic [PORT_W-1:0] w);
    @(posedge i_mclk);
    anc_valid <= 1'b1;
    anc_word <= w;
    @(posedge i_mclk);
    anc_valid <= 1'b0;
  endtask : pulse_anc

  task automatic send(input int n);
    @(posedge i_mclk);
    for (int k = 0; k < n; k++)
    begin
      lfsr_s = lfsr(lfsr_s);
      vid_valid <= 1'b1;
      luma <= lfsr_s[9:0];
      chroma <= ~lfsr_s[15:6];
      @(posedge i_mclk);
      while (in_ready !== 1'b1)
        @(posedge i_mclk);
      vq.push_back({lfsr_s[9:0], ~lfsr_s[15:6]});
    end
    vid_valid <= 1'b0;
  endtask : send

  task automatic drain();
    for (int k = 0; k < 400 && vq.size() != 0; k++)
      @(posedge i_mclk);
    check(20'(vq.size()), 20'h0);
  endtask : drain

  // A rising edge of the oscillator, or a rate tick, then a look two cycles on.
  task automatic fire(input logic up);
    @(posedge i_mclk);
    vcxo <= 1'b0;
    @(posedge i_mclk);
    if (up)
      tick <= 1'b1;
    else
      vcxo <= 1'b1;
    @(posedge i_mclk);
    tick <= 1'b0;
    settle(2);
  endtask : fire

  always @(posedge i_mclk)
    if (cap_v === 1'b1)
      check(cap_d, (vq.size() != 0) ? vq.pop_front() : ~cap_d);

  always @(negedge i_mclk)
    if (rd_pend)
    begin
      rd_pend = 1'b0;
      check(20'(port_wire & rd_mask), 20'(rq.pop_front()));
    end

  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  initial
  begin
    #400000;
    errors++;
    summarize();
  end

  initial
  begin
    {i_rst, lock, det_sd_hd, crc_err} = 4'hf;
    {strobe, fsel, rdwr, vid_valid, anc_valid, tick, vcxo, rd_pend} = 8'h00;
    {host_d, anc_word, luma, chroma} = 40'h0;
    mode = 2'h0;
    errors = 0;
    total_checks = 0;
    lfsr_s = lfsr(16'h0044);
    line_num = lfsr_s[10:0];
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    settle(2);
    check(20'({auto_en, trs_en, wclk_oe_n, bias_oe_n, bias}), 20'h19);
    check(20'(io), 20'h18);
    check(20'({crc_o, line_out}), 20'({crc_err, line_num}));
    rd(1'b1, ADDR_FORMAT, 10'h000);
    rd(1'b1, ADDR_VIDCTL, 10'h000);
    pulse_anc(10'h2a5);
    rd(1'b0, 8'h00, 10'h2a5);
    send(8);
    mode <= 2'h1;
    send(6);
    drain();
    mode <= 2'h2;
    repeat (12) @(posedge i_mclk);
    send(2);
    settle(1);
    check(20'(in_ready), 20'h0);
    mode <= 2'h0;
    send(4);
    drain();
    det_sd_hd <= 1'b0;
    port_op(1'b1, 1'b0, {CTRL_TAG, ADDR_FORMAT});
    port_op(1'b1, 1'b0, 10'h23f);
    port_op(1'b1, 1'b0, 10'h33f);
    settle(2);
    check(20'({auto_en, trs_en}), 20'h0);
    check(20'({crc_o, line_out}), 20'h0);
    check(20'(io), 20'h18);
    rd(1'b1, ADDR_FORMAT, 10'h03f);
    pulse_anc(10'h155);
    port_op(1'b0, 1'b1, 10'h000);
    settle(1);
    check(20'(port_wire === 10'h155), 20'h0);
    send(6);
    drain();
    wr(8'h20, 8'haa);
    rd(1'b1, 8'h20, 10'h000);
    rd(1'b1, ADDR_FORMAT, 10'h03f);
    mode <= 2'h2;
    wr(ADDR_VIDCTL, 8'h01 << VIDCTL_EXT_CLK_BIT);
    settle(4);
    check(20'({wclk_oe_n, bias_oe_n}), 20'h3);
    fire(1'b0);
    check(20'({bias_oe_n, bias}), 20'h0);
    fire(1'b1);
    fire(1'b1);
    check(20'({bias_oe_n, bias}), 20'h1);
    rd(1'b1, ADDR_VIDCTL, 10'h001);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(1'b1, ADDR_FORMAT, 10'h000);
    rd(1'b1, ADDR_VIDCTL, 10'h000);
    settle(1);
    check(20'(wclk_oe_n), 20'h0);
    summarize();
  end
endmodule : focc_top_tb_top
`default_nettype wire
